// [design/ifd_decoder.sv]
`default_nettype none
module ifd_decoder
    import ifd_pkg::*;
#(
    parameter int OSC_PER_CYCLE = ifd_pkg::OSC_PER_CYC,
    parameter bit EXT_ENABLE    = 1'b1
)
(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic [15:0]       prog_word,
    input  wire logic              prog_valid,
    input  wire logic              cond_true,
    output logic                   fetch_req,
    output logic                   cycle_strobe,
    output logic                   instr_valid,
    output ifd_pkg::ifd_class_t    instr_class,
    output logic [3:0]             opcode,
    output logic [7:0]             file_addr,
    output logic                   dest_to_file,
    output logic                   dest_to_accum,
    output logic                   use_bank_selector,
    output logic [2:0]             bit_num,
    output logic [1:0]             indirect_pointer_sel,
    output logic                   shadow_mode,
    output logic [1:0]             table_mode,
    output logic [31:0]            full_instr,
    output logic                   exec_nop,
    output logic                   flush
);
    import ifd_pkg::*;

    // divider is four bits wide; one-period cycles cannot prefetch
    if (OSC_PER_CYCLE < 2 || OSC_PER_CYCLE > 16)
    begin : g_bad_div
        $error("OSC_PER_CYCLE out of range");
    end

    typedef enum logic [1:0] {
        ST_FIRST,
        ST_SECOND,
        ST_EXTRA
    } ifd_state_t;

    ifd_fields_if fi ();
    ifd_classify u_cls (.f(fi.dec));

    logic [3:0]  osc_q, osc_d;
    logic        tick;
    ifd_state_t  st_q, st_d;
    logic [15:0] first_q, first_d;
    logic        pend_branch_q, pend_branch_d;
    logic        fetch_q, fetch_d;
    logic        cyc_q, cyc_d;
    logic        vld_q, vld_d;
    ifd_class_t  cls_q, cls_d;
    logic [3:0]  op_q, op_d;
    logic [7:0]  fa_q, fa_d;
    logic        dfile_q, dfile_d;
    logic        dacc_q, dacc_d;
    logic        bank_q, bank_d;
    logic [2:0]  bit_q, bit_d;
    logic [1:0]  ptr_q, ptr_d;
    logic        sh_q, sh_d;
    logic [1:0]  tm_q, tm_d;
    logic [31:0] full_q, full_d;
    logic        nop_q, nop_d;
    logic        flush_q, flush_d;

    assign fi.word = (st_q == ST_SECOND) ? first_q : prog_word;

    always_comb
    begin
        tick  = osc_q == 4'(OSC_PER_CYCLE - 1);
        osc_d = tick ? 4'h 0 : osc_q + 4'h 1;
    end

    always_comb
    begin
        st_d          = st_q;
        first_d       = first_q;
        pend_branch_d = pend_branch_q;
        fetch_d       = tick;
        cyc_d         = tick;
        vld_d         = 1'b0;
        cls_d         = cls_q;
        op_d          = op_q;
        fa_d          = fa_q;
        dfile_d       = dfile_q;
        dacc_d        = dacc_q;
        bank_d        = bank_q;
        bit_d         = bit_q;
        ptr_d         = ptr_q;
        sh_d          = sh_q;
        tm_d          = tm_q;
        full_d        = full_q;
        nop_d         = 1'b0;
        flush_d       = 1'b0;
        if (tick)
        begin
            case (st_q)
                ST_FIRST:
                begin
                    if (!prog_valid
                        || prog_word[15:12] == SECOND_TAG
                        || (fi.is_ext && !EXT_ENABLE))
                    begin
                        nop_d = 1'b1;
                    end
                    else if (fi.two_word)
                    begin
                        first_d       = prog_word;
                        pend_branch_d = fi.is_branch;
                        st_d          = ST_SECOND;
                    end
                    else
                    begin
                        vld_d   = 1'b1;
                        cls_d   = fi.cls;
                        op_d    = prog_word[15:12];
                        fa_d    = prog_word[F_MSB:F_LSB];
                        dfile_d = fi.uses_dest && prog_word[D_POS];
                        dacc_d  = fi.uses_dest && !prog_word[D_POS];
                        bank_d  = fi.uses_access && prog_word[A_POS];
                        bit_d   = prog_word[B_MSB:B_LSB];
                        ptr_d   = prog_word[PTR_MSB:PTR_LSB];
                        sh_d    = fi.uses_shadow_mode && prog_word[S_POS];
                        tm_d    = fi.uses_table_mode
                                  ? prog_word[M_MSB:M_LSB] : 2'b00;
                        full_d  = {16'h 0000, prog_word};
                        // extra cycle on a taken skip (cond_true) or a branch
                        if ((fi.is_skip && cond_true) || fi.is_branch)
                        begin
                            flush_d = 1'b1;
                            st_d    = ST_EXTRA;
                        end
                    end
                end
                ST_SECOND:
                begin
                    vld_d   = 1'b1;
                    cls_d   = fi.cls;
                    op_d    = first_q[15:12];
                    fa_d    = first_q[F_MSB:F_LSB];
                    dfile_d = 1'b0;
                    dacc_d  = 1'b0;
                    bank_d  = 1'b0;
                    ptr_d   = first_q[PTR_MSB:PTR_LSB];
                    sh_d    = fi.uses_shadow_mode && first_q[S_POS];
                    tm_d    = 2'b00;
                    full_d  = {first_q, prog_word};
                    if (pend_branch_q)
                    begin
                        flush_d = 1'b1;
                        st_d    = ST_EXTRA;
                    end
                    else
                    begin
                        st_d = ST_FIRST;
                    end
                end
                ST_EXTRA:
                begin
                    nop_d = 1'b1;
                    st_d  = ST_FIRST;
                end
                default:
                begin
                    st_d = ST_FIRST;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            osc_q         <= 4'h 0;
            st_q          <= ST_FIRST;
            first_q       <= NOP_WORD;
            pend_branch_q <= 1'b0;
            fetch_q       <= 1'b0;
            cyc_q         <= 1'b0;
            vld_q         <= 1'b0;
            cls_q         <= CLS_BYTE;
            op_q          <= 4'h 0;
            fa_q          <= 8'h 00;
            dfile_q       <= 1'b0;
            dacc_q        <= 1'b0;
            bank_q        <= 1'b0;
            bit_q         <= 3'h 0;
            ptr_q         <= 2'h 0;
            sh_q          <= 1'b0;
            tm_q          <= 2'h 0;
            full_q        <= 32'h 0000_0000;
            nop_q         <= 1'b0;
            flush_q       <= 1'b0;
        end
        else
        begin
            osc_q         <= osc_d;
            st_q          <= st_d;
            first_q       <= first_d;
            pend_branch_q <= pend_branch_d;
            fetch_q       <= fetch_d;
            cyc_q         <= cyc_d;
            vld_q         <= vld_d;
            cls_q         <= cls_d;
            op_q          <= op_d;
            fa_q          <= fa_d;
            dfile_q       <= dfile_d;
            dacc_q        <= dacc_d;
            bank_q        <= bank_d;
            bit_q         <= bit_d;
            ptr_q         <= ptr_d;
            sh_q          <= sh_d;
            tm_q          <= tm_d;
            full_q        <= full_d;
            nop_q         <= nop_d;
            flush_q       <= flush_d;
        end
    end

    assign fetch_req            = fetch_q;
    assign cycle_strobe         = cyc_q;
    assign instr_valid          = vld_q;
    assign instr_class          = cls_q;
    assign opcode               = op_q;
    assign file_addr            = fa_q;
    assign dest_to_file         = dfile_q;
    assign dest_to_accum        = dacc_q;
    assign use_bank_selector    = bank_q;
    assign bit_num              = bit_q;
    assign indirect_pointer_sel = ptr_q;
    assign shadow_mode          = sh_q;
    assign table_mode           = tm_q;
    assign full_instr           = full_q;
    assign exec_nop             = nop_q;
    assign flush                = flush_q;
endmodule : ifd_decoder
`default_nettype wire

// [design/ifd_pkg.sv]
`default_nettype none
package ifd_pkg;
    localparam int          WORD_W        = 16;
    localparam int          OSC_PER_CYC   = 4;
    localparam int          BASE_COUNT    = 75;
    localparam int          EXT_COUNT     = 8;
    localparam logic [3:0]  SECOND_TAG    = 4'h f;
    localparam int          F_LSB         = 0;
    localparam int          F_MSB         = 7;
    localparam int          A_POS         = 8;
    localparam int          D_POS         = 9;
    localparam int          B_LSB         = 9;
    localparam int          B_MSB         = 11;
    localparam int          PTR_LSB       = 4;
    localparam int          PTR_MSB       = 5;
    localparam int          S_POS         = 0;
    localparam int          M_LSB         = 0;
    localparam int          M_MSB         = 1;
    localparam logic [15:0] NOP_WORD      = 16'h 0000;

    typedef enum logic [1:0] {
        CLS_BYTE,
        CLS_BIT,
        CLS_LIT,
        CLS_CTRL
    } ifd_class_t;

    typedef enum logic [1:0] {
        PH_Q1,
        PH_Q2,
        PH_Q3,
        PH_Q4
    } ifd_phase_t;
endpackage : ifd_pkg
`default_nettype wire

// [design/ifd_fields_if.sv]
`default_nettype none
interface ifd_fields_if;
    import ifd_pkg::*;
    logic [15:0] word;
    ifd_class_t  cls;
    logic        two_word;
    logic        is_branch;
    logic        is_skip;
    logic        is_ext;
    logic        uses_dest;
    logic        uses_access;
    logic        uses_ptr;
    logic        uses_shadow_mode;
    logic        uses_table_mode;
    modport dec (input word, output cls, two_word, is_branch, is_skip,
                 is_ext, uses_dest, uses_access, uses_ptr,
                 uses_shadow_mode, uses_table_mode);
    modport core (output word, input cls, two_word, is_branch, is_skip,
                  is_ext, uses_dest, uses_access, uses_ptr,
                  uses_shadow_mode, uses_table_mode);
endinterface : ifd_fields_if
`default_nettype wire

// [design/ifd_classify.sv]
`default_nettype none
module ifd_classify
    import ifd_pkg::*;
(
    ifd_fields_if.dec f
);
    logic [3:0] op;
    assign op = f.word[15:12];

    always_comb
    begin
        f.cls              = CLS_BYTE;
        f.two_word         = 1'b0;
        f.is_branch        = 1'b0;
        f.is_skip          = 1'b0;
        f.is_ext           = 1'b0;
        f.uses_dest        = 1'b0;
        f.uses_access      = 1'b0;
        f.uses_ptr         = 1'b0;
        f.uses_shadow_mode = 1'b0;
        f.uses_table_mode  = 1'b0;
        case (op)
            4'h 0:
            begin
                if (f.word[11:8] == 4'h 0)
                begin
                    f.cls = CLS_CTRL;
                    f.uses_shadow_mode = f.word[7:1] == 7'h 08;
                    f.is_branch = f.word[7:2] == 6'h 04;
                    f.uses_table_mode = f.word[7:4] == 4'h 0
                                        && f.word[3];
                end
                else
                begin
                    f.cls = CLS_LIT;
                end
            end
            4'h 1, 4'h 2, 4'h 3, 4'h 4, 4'h 5, 4'h 6:
            begin
                f.cls         = CLS_BYTE;
                f.uses_dest   = op != 4'h 6;
                f.uses_access = 1'b1;
                f.is_skip     = op == 4'h 6 && f.word[11:10] != 2'b11;
            end
            4'h 7, 4'h 8, 4'h 9, 4'h a, 4'h b:
            begin
                f.cls         = CLS_BIT;
                f.uses_access = 1'b1;
                f.is_skip     = op == 4'h a || op == 4'h b;
            end
            4'h c:
            begin
                f.cls      = CLS_BYTE;
                f.two_word = 1'b1;
            end
            4'h d:
            begin
                f.cls       = CLS_CTRL;
                f.is_branch = 1'b1;
            end
            4'h e:
            begin
                f.cls = CLS_CTRL;
                if (f.word[11:9] == 3'b111)
                begin
                    f.two_word = 1'b1;
                    if (f.word[8])
                    begin
                        f.cls      = CLS_LIT;
                        f.uses_ptr = 1'b1;
                    end
                    else
                    begin
                        f.is_branch = 1'b1;
                    end
                end
                else if (f.word[11:9] == 3'b110)
                begin
                    f.two_word         = 1'b1;
                    f.is_branch        = 1'b1;
                    f.uses_shadow_mode = 1'b1;
                end
                else
                begin
                    f.is_branch = 1'b1;
                end
            end
            4'h f:
            begin
                // lone second word acts as no-op
                f.cls = CLS_CTRL;
            end
            default:
            begin
                f.cls = CLS_CTRL;
            end
        endcase
        if (op == 4'h e && f.word[11:8] == 4'h 8)
        begin
            f.is_ext = 1'b1;
            f.cls    = CLS_LIT;
        end
    end
endmodule : ifd_classify
`default_nettype wire

// [tb/ifd_decoder_props.sv]
`default_nettype none
module ifd_decoder_chk
    import ifd_pkg::*;
#(
    parameter int OSC_PER_CYCLE = 4,
    parameter bit EXT_ENABLE    = 1'b1
)
(
    input wire logic               clk_sys,
    input wire logic               rst,
    input wire logic               fetch_req,
    input wire logic               cycle_strobe,
    input wire logic               instr_valid,
    input wire ifd_pkg::ifd_class_t instr_class,
    input wire logic [3:0]         opcode,
    input wire logic [7:0]         file_addr,
    input wire logic               dest_to_file,
    input wire logic               dest_to_accum,
    input wire logic               use_bank_selector,
    input wire logic [2:0]         bit_num,
    input wire logic [31:0]        full_instr,
    input wire logic               exec_nop,
    input wire logic               flush
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int NOP_GAP = OSC_PER_CYCLE;
    logic [7:0] cnt_q;
    logic [7:0] cnt_d;
    logic       seen_q;
    logic       seen_d;
    logic       one_w;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    assign one_w = (full_instr[31:16] == 16'h0000);

    // clocks since the last cycle pulse
    always_comb
    begin
        cnt_d = fetch_req ? 8'h00 : cnt_q + 8'h01;
        seen_d = seen_q | fetch_req;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            cnt_q <= 8'h00;
            seen_q <= 1'b0;
        end
        else
        begin
            cnt_q <= cnt_d;
            seen_q <= seen_d;
        end
    end

    strobe_pair_a: assert property (fetch_req == cycle_strobe)
        else $error("cycle strobe and fetch request differ");
    cycle_period_a: assert property (fetch_req && seen_q |->
        cnt_q == 8'(OSC_PER_CYCLE - 1))
        else $error("instruction cycle length wrong");
    cycle_gap_a: assert property (seen_q |->
        cnt_q < 8'(OSC_PER_CYCLE))
        else $error("instruction cycle pulse missing");
    result_on_tick_a: assert property ((instr_valid || exec_nop) |->
        cycle_strobe && !(instr_valid && exec_nop))
        else $error("result outside a cycle pulse");
    dest_select_a: assert property (instr_valid && one_w &&
        instr_class == CLS_BYTE |->
        dest_to_file == (full_instr[9] && opcode != 4'h6)
        && dest_to_accum == (!full_instr[9] && opcode != 4'h6))
        else $error("destination select wrong");
    bank_select_a: assert property (instr_valid && one_w &&
        instr_class inside {CLS_BYTE, CLS_BIT} |->
        use_bank_selector == full_instr[8])
        else $error("access bank select wrong");
    bit_number_a: assert property (instr_valid && one_w &&
        instr_class == CLS_BIT |-> bit_num == full_instr[11:9])
        else $error("bit number wrong");
    field_split_a: assert property (instr_valid && one_w |->
        opcode == full_instr[15:12] && file_addr == full_instr[7:0])
        else $error("opcode or file address wrong");
    second_tag_a: assert property (instr_valid && !one_w |->
        full_instr[15:12] == SECOND_TAG)
        else $error("second word tag wrong");
    flush_nop_a: assert property (flush |-> ##NOP_GAP exec_nop)
        else $error("no idle cycle after discard");
    reset_quiet_a: assert property ($past(rst) |->
        !fetch_req && !instr_valid && !exec_nop)
        else $error("output active after reset");
endmodule : ifd_decoder_chk
`default_nettype wire

// [tb/ifd_prog_mem.sv]
`default_nettype none
module ifd_prog_mem
(
    input  wire logic   clk_sys,
    input  wire logic   rst,
    input  wire logic   fetch_req,
    output logic [15:0] prog_word,
    output logic        prog_valid,
    output logic        cond_true
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] mem[8];
    logic        cond[8];
    int          len = 0;
    logic [3:0]  ptr_q = 4'h0;
    logic [15:0] last_q = 16'h0000;

    // words go out in order; dropping them is the core's job
    always @(posedge clk_sys)
    begin
        if (rst)
            ptr_q <= 4'h0;
        else if (fetch_req)
            ptr_q <= ptr_q + 4'h1;
        if (prog_valid)
            last_q <= prog_word;
    end

    always_comb
    begin
        prog_valid = int'(ptr_q) < len;
        // past the end: no stale word on the bus
        prog_word = prog_valid ? mem[ptr_q[2:0]] : ~last_q;
        cond_true = prog_valid & cond[ptr_q[2:0]];
    end
endmodule : ifd_prog_mem
`default_nettype wire

// [tb/test_mcu_instruction_format_decoder.sv]
`default_nettype none
module test_mcu_instruction_format_decoder
    import ifd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys = 1'b0;
    logic        rst = 1'b1;
    logic [15:0] prog_word;
    logic        prog_valid;
    logic        cond_true;
    logic        fetch_req;
    logic        cycle_strobe;
    logic        instr_valid;
    ifd_class_t  instr_class;
    logic [3:0]  opcode;
    logic [7:0]  file_addr;
    logic        dest_to_file;
    logic        dest_to_accum;
    logic        use_bank_selector;
    logic [2:0]  bit_num;
    logic        shadow_mode;
    logic [1:0]  indirect_pointer_sel;
    logic [1:0]  table_mode;
    logic [31:0] full_instr;
    logic        exec_nop;
    logic        flush;
    logic [1:0]  k_s[8];
    logic        f_s[8];
    ifd_class_t  c_s[8];
    logic [31:0] w_s[8];
    logic [2:0]  d_s[8];
    logic [2:0]  b_s[8];
    logic        s_s[8];
    logic [1:0]  p_s[8];
    logic [1:0]  m_s[8];
    int          t_s[8];
    logic [15:0] prog[$];
    int          cmask;
    int          cyc = 0;
    int          num_errors = 0;
    int          n_compared = 0;

    always #50 clk_sys = ~clk_sys;

    ifd_prog_mem u_mem (.clk_sys(clk_sys), .rst(rst),
        .fetch_req(fetch_req), .prog_word(prog_word),
        .prog_valid(prog_valid), .cond_true(cond_true));

    ifd_decoder DUT (.clk_sys(clk_sys), .rst(rst),
        .prog_word(prog_word), .prog_valid(prog_valid),
        .cond_true(cond_true), .fetch_req(fetch_req),
        .cycle_strobe(cycle_strobe), .instr_valid(instr_valid),
        .instr_class(instr_class), .opcode(opcode),
        .file_addr(file_addr), .dest_to_file(dest_to_file),
        .dest_to_accum(dest_to_accum),
        .use_bank_selector(use_bank_selector), .bit_num(bit_num),
        .indirect_pointer_sel(indirect_pointer_sel),
        .shadow_mode(shadow_mode), .table_mode(table_mode),
        .full_instr(full_instr),
        .exec_nop(exec_nop), .flush(flush));

    task finish_test;
        if (num_errors == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    always @(posedge clk_sys)
    begin
        cyc <= cyc + 1;
        // whole run needs under two hundred cycles
        if (cyc == 3000)
        begin
            num_errors++;
            finish_test();
        end
    end

    task chk(input string what, input logic [35:0] e, input logic [35:0] g);
        n_compared++;
        if (g !== e)
        begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask : chk

    // reset, load the program, record each instruction cycle pulse
    task run(input int n);
        int i;
        int guard;
        @(posedge clk_sys) rst <= 1'b1;
        // load only once the core is held, so no word moves under a tick
        @(posedge clk_sys);
        for (i = 0; i < prog.size(); i++)
        begin
            u_mem.mem[i] = prog[i];
            u_mem.cond[i] = cmask[i];
        end
        u_mem.len = prog.size();
        @(posedge clk_sys);
        rst <= 1'b0;
        i = 0;
        guard = 0;
        while (i < n && guard < 100)
        begin
            @(negedge clk_sys);
            guard++;
            if (cycle_strobe === 1'b1)
            begin
                k_s[i] = {instr_valid, exec_nop};
                f_s[i] = flush;
                c_s[i] = instr_class;
                w_s[i] = full_instr;
                d_s[i] = {dest_to_file, dest_to_accum, use_bank_selector};
                b_s[i] = bit_num;
                s_s[i] = shadow_mode;
                p_s[i] = indirect_pointer_sel;
                m_s[i] = table_mode;
                t_s[i] = cyc;
                i++;
            end
        end
        chk("pulses", n, i);
    endtask : run

    task t_byte;
        prog = '{16'h23a5, 16'h205a};
        cmask = 0;
        run(2);
        chk("byte0", {2'b10, CLS_BYTE, 3'b101}, {k_s[0], c_s[0], d_s[0]});
        chk("byte1", {3'b010, 16'h205a}, {d_s[1], w_s[1][15:0]});
        chk("cycle", 4, t_s[1] - t_s[0]);
    endtask : t_byte

    task t_bit;
        prog = '{16'h7e3c, 16'h713c};
        cmask = 0;
        run(2);
        chk("bit0", {2'b10, CLS_BIT, 4'he}, {k_s[0], c_s[0], b_s[0], d_s[0][0]});
        chk("bit1", {2'b10, CLS_BIT, 4'h1}, {k_s[1], c_s[1], b_s[1], d_s[1][0]});
    endtask : t_bit

    task t_branch;
        prog = '{16'hd005, 16'h2300, 16'h2400};
        cmask = 0;
        run(3);
        chk("br0", {2'b10, 1'b1, CLS_CTRL}, {k_s[0], f_s[0], c_s[0]});
        chk("br1", 2'b01, k_s[1]);
        chk("br2", {2'b10, 32'h0000_2400}, {k_s[2], w_s[2]});
    endtask : t_branch

    task t_skip;
        prog = '{16'ha13c, 16'h2300, 16'h2400};
        cmask = 1;
        run(3);
        chk("skip1", 2'b01, k_s[1]);
        chk("skip2", {2'b10, 32'h0000_2400}, {k_s[2], w_s[2]});
        prog = '{16'hb13c, 16'h2300};
        cmask = 0;
        run(2);
        chk("noskip", {2'b10, 32'h0000_2300}, {k_s[1], w_s[1]});
    endtask : t_skip

    task t_two;
        prog = '{16'hc123, 16'hf456, 16'h2300};
        cmask = 0;
        run(3);
        chk("pair", {2'b10, 32'hc123_f456}, {k_s[1], w_s[1]});
        chk("after", {2'b10, 32'h0000_2300}, {k_s[2], w_s[2]});
    endtask : t_two

    task t_goto;
        prog = '{16'hee12, 16'hf345, 16'h2300, 16'h2400};
        cmask = 0;
        run(4);
        chk("goto1", {2'b10, CLS_CTRL, 32'hee12_f345}, {k_s[1], c_s[1], w_s[1]});
        chk("goto2", 2'b01, k_s[2]);
        chk("goto3", {2'b10, 32'h0000_2400}, {k_s[3], w_s[3]});
    endtask : t_goto

    task t_lone;
        prog = '{16'hf123, 16'h2300};
        cmask = 0;
        run(2);
        chk("lone0", 2'b01, k_s[0]);
        chk("lone1", {2'b10, 32'h0000_2300}, {k_s[1], w_s[1]});
    endtask : t_lone

    task t_call;
        prog = '{16'hec01, 16'hf000, 16'h2300, 16'hec00, 16'hf000};
        cmask = 0;
        run(5);
        chk("fast", {2'b10, 1'b1}, {k_s[1], s_s[1]});
        chk("plain", {2'b10, 1'b0}, {k_s[4], s_s[4]});
    endtask : t_call

    task t_lit;
        prog = '{16'h0a55, 16'h000a, 16'hef25, 16'hf0bc, 16'he812};
        cmask = 0;
        run(5);
        chk("lit", {2'b10, CLS_LIT}, {k_s[0], c_s[0]});
        chk("litw", 16'h0a55, w_s[0][15:0]);
        chk("table", {2'b10, CLS_CTRL, 2'b10}, {k_s[1], c_s[1], m_s[1]});
        chk("ptr", {CLS_LIT, 2'b10}, {c_s[3], p_s[3]});
        chk("ptrw", 32'hef25_f0bc, w_s[3]);
        chk("ext", {2'b10, CLS_LIT}, {k_s[4], c_s[4]});
    endtask : t_lit

    initial
    begin
        t_byte();
        t_bit();
        t_branch();
        t_skip();
        t_two();
        t_goto();
        t_lone();
        t_call();
        t_lit();
        finish_test();
    end
endmodule : test_mcu_instruction_format_decoder

bind ifd_decoder ifd_decoder_chk #(.OSC_PER_CYCLE(OSC_PER_CYCLE),
    .EXT_ENABLE(EXT_ENABLE)) u_chk (.clk_sys(clk_sys), .rst(rst),
    .fetch_req(fetch_req), .cycle_strobe(cycle_strobe),
    .instr_valid(instr_valid), .instr_class(instr_class),
    .opcode(opcode), .file_addr(file_addr),
    .dest_to_file(dest_to_file), .dest_to_accum(dest_to_accum),
    .use_bank_selector(use_bank_selector), .bit_num(bit_num),
    .full_instr(full_instr), .exec_nop(exec_nop), .flush(flush));
`default_nettype wire
